// >>> rtl/stmc_consts.vh
// constants for the ten bit timer mode control block
`ifndef STMC_CONSTS_VH
`define STMC_CONSTS_VH
// register offsets on the plain register port
`define STMC_OFS_CTRL0 3'h0
`define STMC_OFS_CTRL1 3'h1
`define STMC_OFS_CNTL 3'h2
`define STMC_OFS_CNTH 3'h3
`define STMC_OFS_CMPAL 3'h4
`define STMC_OFS_CMPAH 3'h5
// control 0 fields
`define STMC_C0_RUN 3
`define STMC_C0_PER_HI 2
`define STMC_C0_PER_LO 0
// control 1 fields
`define STMC_C1_MODE_HI 7
`define STMC_C1_MODE_LO 6
`define STMC_C1_ACT_HI 5
`define STMC_C1_ACT_LO 4
`define STMC_C1_INIT 3
`define STMC_C1_INV 2
`define STMC_C1_SWAP 1
`define STMC_C1_CLR 0
// mode and pin action codes
`define STMC_MODE_CMP 2'h0
`define STMC_MODE_PWM 2'h2
`define STMC_MODE_TMR 2'h3
`define STMC_ACT_00 2'h0
`define STMC_ACT_01 2'h1
`define STMC_ACT_10 2'h2
`define STMC_ACT_11 2'h3
// reset values and counter limits
`define STMC_RST_BYTE 8'h00
`define STMC_CNT_ZERO 10'h000
`define STMC_CNT_MAX 10'h3ff
`define STMC_PER_ZERO 3'h0
`endif

// >>> rtl/stmc_timer.v
// ten bit timer with mode, output pin control and counter read back
`include "stmc_consts.vh"

// Contract
// - run rising edge restores pin initial level
// - period bits compare counter bits nine..seven
// - period zero: clear on overflow only
// - mode field selects compare, pwm, timer
// - timer mode: pin, level, invert unused
// - pwm actions: inactive, active, pwm, pulse
// - same level as initial shows nothing
// - initial level sets pin before match
// - initial level selects pwm active level
// - invert bit inverts output pin
// - swap bit exchanges pwm period and duty
// - clear source: compare a or period
// - clear source ignored in pwm modes
// - low byte read only, counter bits low
// - high byte read latches low byte buffer
// - run rise zeroes counter, fall holds
// - ten bit up counter on timer clock
module stmc_timer (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// timer count enable, one cycle per timer clock
	input wire tick_i,
	// register port
	input wire [2:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// timer output pin
	output reg pin_o,
	output reg pin_oe_n_o,
	// match events, one cycle pulses
	output reg match_a_o,
	output reg match_p_o
);

	reg [7:0] ctrl0_reg;
	reg [7:0] ctrl1_reg;
	reg [9:0] cmpa_reg;
	reg [7:0] wbuf_reg;
	reg [7:0] rbuf_reg;
	reg [9:0] cnt_reg;
	reg run_d_reg;
	reg level_reg;
	reg pulse_reg;
	reg tick_s1_reg;
	reg tick_s2_reg;
	reg tick_d_reg;

	wire run = ctrl0_reg[`STMC_C0_RUN];
	wire [2:0] per = ctrl0_reg[`STMC_C0_PER_HI:`STMC_C0_PER_LO];
	wire [1:0] mode = ctrl1_reg[`STMC_C1_MODE_HI:`STMC_C1_MODE_LO];
	wire [1:0] act = ctrl1_reg[`STMC_C1_ACT_HI:`STMC_C1_ACT_LO];
	wire init_lvl = ctrl1_reg[`STMC_C1_INIT];
	wire inv = ctrl1_reg[`STMC_C1_INV];
	wire swap = ctrl1_reg[`STMC_C1_SWAP];
	wire clr_sel = ctrl1_reg[`STMC_C1_CLR];
	wire run_rise = run & ~run_d_reg;
	wire pwm_mode = (mode == `STMC_MODE_PWM);
	wire cmp_mode = (mode == `STMC_MODE_CMP) | (mode == `STMC_MODE_TMR);
	// tick is re-timed here since the timer clock source may be a pin
	wire tick = tick_s2_reg & ~tick_d_reg;
	wire step = run & tick & ~run_rise;

	// comparators look at the count about to be reached, so a match clears at once
	// and the period is exactly value times 128 timer clocks
	wire [9:0] cnt_inc = cnt_reg + 10'h001;
	wire match_p = (per != `STMC_PER_ZERO) & (cnt_inc == {per, 7'h00});
	wire match_a = (cnt_inc == cmpa_reg) & (cmpa_reg != `STMC_CNT_ZERO);
	wire ovf = (cnt_reg == `STMC_CNT_MAX);

	// pwm duty compare: the clearing comparator sets the period, the other one the duty
	wire [9:0] per_ext = {per, 7'h00};
	wire [9:0] duty = swap ? per_ext : cmpa_reg;
	wire duty_full = (duty == `STMC_CNT_ZERO) & swap;
	wire pwm_act = duty_full | (cnt_reg < duty);

	// counter clear source
	function clr_hit;
		input is_pwm;
		input sel;
		input sw;
		input ma;
		input mp;
		input ov;
		begin
			if (is_pwm) begin
				clr_hit = sw ? ma : (mp | ov);
			end else begin
				clr_hit = sel ? ma : (mp | ov);
			end
		end
	endfunction

	wire clr_now = clr_hit(pwm_mode, clr_sel, swap, match_a, match_p, ovf);

	// timer clock enable synchroniser
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_s1_reg <= 1'b0;
			tick_s2_reg <= 1'b0;
			tick_d_reg <= 1'b0;
		end else begin
			tick_s1_reg <= tick_i;
			tick_s2_reg <= tick_s1_reg;
			tick_d_reg <= tick_s2_reg;
		end
	end

	// register writes, compare a low byte goes through the write buffer
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl0_reg <= `STMC_RST_BYTE;
			ctrl1_reg <= `STMC_RST_BYTE;
			cmpa_reg <= `STMC_CNT_ZERO;
			wbuf_reg <= `STMC_RST_BYTE;
		end else if (wr_i) begin
			case (addr_i)
				`STMC_OFS_CTRL0: ctrl0_reg <= wdata_i;
				`STMC_OFS_CTRL1: ctrl1_reg <= wdata_i;
				`STMC_OFS_CMPAL: wbuf_reg <= wdata_i;
				`STMC_OFS_CMPAH: cmpa_reg <= {wdata_i[1:0], wbuf_reg};
				default: ;
			endcase
		end
	end

	// counter: run rise zeroes, stop holds the residual count
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= `STMC_CNT_ZERO;
			run_d_reg <= 1'b0;
		end else begin
			run_d_reg <= run;
			if (run_rise) begin
				cnt_reg <= `STMC_CNT_ZERO;
			end else if (step) begin
				if (clr_now) begin
					cnt_reg <= `STMC_CNT_ZERO;
				end else begin
					cnt_reg <= cnt_inc;
				end
			end
		end
	end

	// match pulses, taken once per timer clock so a held count does not repeat
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_a_o <= 1'b0;
			match_p_o <= 1'b0;
		end else begin
			match_a_o <= step & match_a;
			// clear on a suppresses the period pulse in every mode but pwm
			match_p_o <= step & match_p & ~(~pwm_mode & clr_sel);
		end
	end

	// output level, before inversion
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else if (run_rise) begin
			level_reg <= init_lvl;
			pulse_reg <= 1'b1;
		end else if (cmp_mode) begin
			// a request equal to the present level changes nothing
			if (step & match_a) begin
				case (act)
					`STMC_ACT_01: level_reg <= 1'b0;
					`STMC_ACT_10: level_reg <= 1'b1;
					`STMC_ACT_11: level_reg <= ~level_reg;
					default: level_reg <= level_reg;
				endcase
			end
		end else if (pwm_mode) begin
			// single pulse ends at the first counter clear
			if (step & clr_now) begin
				pulse_reg <= 1'b0;
			end
			case (act)
				`STMC_ACT_00: level_reg <= ~init_lvl;
				`STMC_ACT_01: level_reg <= init_lvl;
				`STMC_ACT_10: level_reg <= pwm_act ? init_lvl : ~init_lvl;
				default: level_reg <= (pulse_reg & run) ? init_lvl : ~init_lvl;
			endcase
		end
	end

	// pin drive: released in timer mode where the pin is not used
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= 1'b0;
			pin_oe_n_o <= 1'b1;
		end else if (mode == `STMC_MODE_TMR) begin
			pin_o <= 1'b0;
			pin_oe_n_o <= 1'b1;
		end else begin
			pin_o <= level_reg ^ inv;
			pin_oe_n_o <= 1'b0;
		end
	end

	// read data one cycle after the strobe; high byte read loads low buffer
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `STMC_RST_BYTE;
			rbuf_reg <= `STMC_RST_BYTE;
		end else if (rd_i) begin
			case (addr_i)
				`STMC_OFS_CTRL0: rdata_o <= ctrl0_reg;
				`STMC_OFS_CTRL1: rdata_o <= ctrl1_reg;
				`STMC_OFS_CNTL: rdata_o <= rbuf_reg;
				`STMC_OFS_CNTH: begin
					rdata_o <= {6'h00, cnt_reg[9:8]};
					rbuf_reg <= cnt_reg[7:0];
				end
				`STMC_OFS_CMPAL: rdata_o <= cmpa_reg[7:0];
				`STMC_OFS_CMPAH: rdata_o <= {6'h00, cmpa_reg[9:8]};
				default: rdata_o <= `STMC_RST_BYTE;
			endcase
		end else begin
			rdata_o <= `STMC_RST_BYTE;
		end
	end

endmodule // stmc_timer

// >>> testbench/stmc_timer_assertions.sv
// port assertions for the ten bit timer
module stmc_timer_chk (
	input wire clk_i, rst_n_i, wr_i, rd_i, pin_o, pin_oe_n_o, match_p_o,
	input wire [2:0] addr_i,
	input wire [7:0] wdata_i, rdata_o
);
	reg [7:0] c1_reg;
	reg run_reg;
	// shadow of control 1 and run as written, so pin checks know the set-up
	always @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i) {c1_reg, run_reg} <= 9'h000;
		else if (wr_i && addr_i == 3'h1) c1_reg <= wdata_i;
		else if (wr_i && addr_i == 3'h0) run_reg <= wdata_i[3];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_hi; rd_i && addr_i == 3'h3 |=> rdata_o[7:2] == 6'h00; endproperty
	a_hi: assert property (p_hi) else $error("high byte upper bits set");
	property p_oe_tmr; wr_i && addr_i == 3'h1 && wdata_i[7:6] == 2'b11 |-> ##3 pin_oe_n_o; endproperty
	a_oe_tmr: assert property (p_oe_tmr) else $error("pin driven in timer mode");
	property p_oe_cmp; wr_i && addr_i == 3'h1 && wdata_i[7:6] == 2'b00 |-> ##3 !pin_oe_n_o; endproperty
	a_oe_cmp: assert property (p_oe_cmp) else $error("pin not driven in compare mode");
	// run rise in compare mode puts the initial level, inverted if asked, on the pin
	property p_run; wr_i && addr_i == 3'h0 && wdata_i[3] && !run_reg && c1_reg[7:6] == 2'b00
		|-> ##3 pin_o == (c1_reg[3] ^ c1_reg[2]); endproperty
	a_run: assert property (p_run) else $error("pin not at initial level");
	property p_no_p; c1_reg[7:6] != 2'b10 && c1_reg[0] && $stable(c1_reg) |-> !match_p_o; endproperty
	a_no_p: assert property (p_no_p) else $error("period match with clear on a");
	property p_inact; c1_reg[7:4] == 4'h8 && $stable(c1_reg) && c1_reg == $past(c1_reg, 2)
		|-> pin_o == !(c1_reg[3] ^ c1_reg[2]); endproperty
	a_inact: assert property (p_inact) else $error("forced inactive level wrong");
	property p_act; c1_reg[7:4] == 4'h9 && $stable(c1_reg) && c1_reg == $past(c1_reg, 2)
		|-> pin_o == (c1_reg[3] ^ c1_reg[2]); endproperty
	a_act: assert property (p_act) else $error("forced active level wrong");
endmodule // stmc_timer_chk
bind stmc_timer stmc_timer_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
	.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .match_p_o(match_p_o), .addr_i(addr_i),
	.wdata_i(wdata_i), .rdata_o(rdata_o));

// >>> testbench/testbench.sv
// self-checking bench for the ten bit timer
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk_i = 0, rst_n_i = 0, tick_i = 0, wr_i = 0, rd_i = 0;
	reg [2:0] addr_i = 0;
	reg [7:0] wdata_i = 0;
	wire [7:0] rdata_o;
	wire pin_o, pin_oe_n_o, match_a_o, match_p_o;
	integer num_errors = 0, cmp_count = 0, cyc = 0, i, n, mdl = 0, per = 128, run = 0, na = 0;
	stmc_timer i_stmc_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n_o), .match_a_o(match_a_o), .match_p_o(match_p_o));
	always #5 clk_i = ~clk_i;
	// count compare a pulses, each stands one cycle
	always @(posedge clk_i) if (match_a_o === 1'b1) na <= na + 1;
	// hang guard, the run needs well under this many cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	task chk(input [7:0] g, input [7:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
			@(posedge clk_i) wr_i <= 1'b0;
		end
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input [2:0] a, input [7:0] e);
		begin
			@(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
			@(posedge clk_i) rd_i <= 1'b0;
			#1 chk(rdata_o, e);
		end
	endtask
	// ticks last two clocks so the synchroniser sees every edge; model wraps at its period
	task tk(input integer k);
		begin
			repeat (k) begin
				@(posedge clk_i) tick_i <= 1'b1;
				@(posedge clk_i) tick_i <= 1'b0;
			end
			if (run) mdl = (mdl + k) % per;
			repeat (4) @(posedge clk_i);
		end
	endtask
	task rdcnt;
		begin
			rd(3'h3, mdl >> 8);
			rd(3'h2, mdl % 256);
		end
	endtask
	task complete_run;
		begin
			$display("compares %0d mismatches %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		n = $urandom(99755);
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 8; i = i + 1) rd(i, 8'h00);
		n = $urandom & 8'hf7;
		wr(3'h0, n);
		rd(3'h0, n);
		wr(3'h1, n);
		rd(3'h1, n);
		wr(3'h1, 8'h00);
		$display("test registers done");
		// period 1 wraps every 128 steps, stop keeps the count, period 0 overflows
		run = 1;
		wr(3'h0, 8'h09);
		tk($urandom % 100 + 1);
		rdcnt;
		tk(150);
		rdcnt;
		run = 0;
		wr(3'h0, 8'h01);
		tk(3);
		rdcnt;
		{run, mdl, per} = {32'd1, 32'd0, 32'd1024};
		wr(3'h0, 8'h08);
		tk(1030);
		rdcnt;
		$display("test counter done");
		// compare a of 5 clears the counter, each pin action from initial low
		run = 0;
		wr(3'h4, 8'h05);
		wr(3'h5, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			wr(3'h0, 8'h00);
			wr(3'h1, 8'h01 | i << 4);
			wr(3'h0, 8'h08);
			tk(2);
			chk(pin_o, 1'b0);
			tk(3);
			chk(pin_o, i > 1);
		end
		chk(na, 8'h04);
		wr(3'h1, 8'h35);
		tk(0);
		chk(pin_o, 1'b0);
		wr(3'h0, 8'h00);
		for (i = 0; i < 2; i = i + 1) begin
			wr(3'h1, 8'h80 | i << 4);
			tk(0);
			chk(pin_o, i == 0);
		end
		wr(3'h1, 8'hc0);
		tk(0);
		chk(pin_oe_n_o, 1'b1);
		$display("test pin done");
		complete_run;
	end
endmodule // testbench
